// ---- rtl/esp_map.svh ----
`ifndef ESP_MAP_SVH
`define ESP_MAP_SVH
// Register byte offsets, low address byte
`define ESP_A_CTRL 8'h00
`define ESP_A_BAUD 8'h04
`define ESP_A_TXD 8'h08
`define ESP_A_RXD 8'h0c
`define ESP_A_STAT 8'h10
`define ESP_A_DIR 8'h14
`define ESP_A_LATC 8'h18
`define ESP_A_PGL 8'h1c
// Control register fields
`define ESP_C_EN 0
`define ESP_C_SYNC 1
`define ESP_C_MST 2
`define ESP_C_POL 3
`define ESP_C_TXE 4
`define ESP_C_RXE 5
`define ESP_C_WAKE 6
`define ESP_C_ABD 7
`define ESP_C_BRK 8
`define ESP_C_W 9
// Status register fields
`define ESP_S_OVR 2
`define ESP_S_FER 3
`define ESP_S_WAKE 4
// Port bit positions
`define ESP_P_SIX 6
`define ESP_P_SEVEN 7
// Reset values
`define ESP_CTRL_RST 9'h000
`define ESP_BAUD_RST 16'h00ff
`define ESP_DIR_RST 8'hff
`define ESP_LAT_RST 8'h00
`define ESP_LINE_IDLE 1'b1
// Frame counts
`define ESP_LAST_BIT 4'h7
`define ESP_LAST_BRK 4'hb
`define ESP_ABD_LAST 3'h3
`define ESP_ABD_SHIFT 3
`endif

// ---- rtl/esp_pkg.sv ----
package esp_pkg;
  // Transmit and synchronous transfer sequencer
  typedef enum logic [4:0] {
    ESP_TX_IDLE = 5'b00001,
    ESP_TX_START = 5'b00010,
    ESP_TX_DATA = 5'b00100,
    ESP_TX_STOP = 5'b01000,
    ESP_TX_BRK = 5'b10000
  } esp_tx_st_t;
  // Asynchronous receive sequencer
  typedef enum logic [3:0] {
    ESP_RX_IDLE = 4'b0001,
    ESP_RX_START = 4'b0010,
    ESP_RX_DATA = 4'b0100,
    ESP_RX_STOP = 4'b1000
  } esp_rx_st_t;
  // Serial request for one pin
  typedef struct packed {
    logic out;
    logic oe;
  } esp_drv_t;
  // Captured bus address phase
  typedef struct packed {
    logic vld;
    logic wr;
    logic [7:0] addr;
  } esp_aph_t;
endpackage

// ---- rtl/esp_brg.sv ----
`timescale 1ns/10ps
module esp_brg (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [15:0] period,
  output logic tick
);
  logic [15:0] cnt_ff;

  // One bit time is period plus one cycles
  assign tick = run & ~load & (cnt_ff == 16'h0000);

  // Down counter, reloaded on each tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 16'h0000;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (run) begin
      cnt_ff <= tick ? period : cnt_ff - 16'h0001;
    end
  end
endmodule

// ---- rtl/esp_pins.sv ----
`timescale 1ns/10ps
`include "esp_map.svh"
module esp_pins (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  input wire logic od,
  input wire logic [1:0] dir,
  input wire logic [1:0] lat,
  input wire esp_pkg::esp_drv_t drv6,
  input wire esp_pkg::esp_drv_t drv7,
  input wire logic pin6_i,
  input wire logic pin7_i,
  output logic pin6_o,
  output logic pin6_oe,
  output logic pin7_o,
  output logic pin7_oe,
  output logic s6,
  output logic s7
);
  logic [1:0] m6_ff;
  logic [1:0] m7_ff;

  // Serial logic owns direction once enabled; else the port bits do
  wire o6 = en ? drv6.out : lat[0];
  wire e6 = en ? drv6.oe : ~dir[0];
  wire o7 = en ? drv7.out : lat[1];
  wire e7 = en ? drv7.oe : ~dir[1];

  assign s6 = m6_ff[1];
  assign s7 = m7_ff[1];

  // Two-stage synchronisers, idle high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m6_ff <= {2{`ESP_LINE_IDLE}};
      m7_ff <= {2{`ESP_LINE_IDLE}};
    end else begin
      m6_ff <= {m6_ff[0], pin6_i};
      m7_ff <= {m7_ff[0], pin7_i};
    end
  end

  // Registered drivers; open drain only ever pulls low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin6_o <= 1'b0;
      pin6_oe <= 1'b0;
      pin7_o <= 1'b0;
      pin7_oe <= 1'b0;
    end else begin
      pin6_o <= od ? 1'b0 : o6;
      pin6_oe <= od ? (e6 & ~o6) : e6;
      pin7_o <= o7;
      pin7_oe <= e7;
    end
  end
endmodule

// ---- rtl/esp_top.sv ----
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "esp_map.svh"
// How it works
// - Asynchronous mode sends on transmit pin and receives on receive pin together.
// - Synchronous mode is half-duplex on one data line, master or slave.
// - Synchronous clock polarity selectable, inverting idle level and active edge.
// - Asynchronous wake-up flag raised when a received break ends.
// - Auto-baud times incoming sync character and loads the baud divisor.
// - Break transmission lasts twelve bit periods.
// - Once enabled, serial logic sets pin directions itself.
// - Open-drain select makes transmit pin only pull low or release.
module esp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic port_c_line_six_i,
  output logic port_c_line_six_o,
  output logic port_c_line_six_oe,
  input wire logic port_c_line_seven_i,
  output logic port_c_line_seven_o,
  output logic port_c_line_seven_oe,
  output logic wake_o
);
  esp_pkg::esp_aph_t aph_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [`ESP_C_W-1:0] ctrl_ff;
  logic [15:0] baud_ff;
  logic [7:0] dir_ff;
  logic [7:0] latc_ff;
  logic [7:0] pgl_ff;
  logic [7:0] rxbuf_ff;
  logic rxv_ff;
  logic ovr_ff;
  logic fer_ff;
  logic wkf_ff;
  esp_pkg::esp_tx_st_t tx_st_ff;
  logic [7:0] tsh_ff;
  logic [3:0] tcnt_ff;
  logic tline_ff;
  logic sdir_ff;
  logic k_ff;
  logic kprev_ff;
  esp_pkg::esp_rx_st_t rx_st_ff;
  logic [7:0] rsh_ff;
  logic [3:0] rcnt_ff;
  logic rx_prev_ff;
  logic abd_run_ff;
  logic [2:0] abd_edges_ff;
  logic [18:0] abd_cnt_ff;
  logic s6;
  logic s7;
  logic ttick;
  logic rtick;
  esp_pkg::esp_drv_t d6;
  esp_pkg::esp_drv_t d7;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Bus decode; writes land in the data phase
  wire acc = hsel & htrans[1] & hready;
  wire rd = acc & ~hwrite;
  wire [7:0] ra = haddr[7:0];
  wire [7:0] wa = aph_ff.addr;
  wire wr_d = aph_ff.vld & aph_ff.wr;
  wire w_ctrl = wr_d & hit(wa, `ESP_A_CTRL);
  wire w_baud = wr_d & hit(wa, `ESP_A_BAUD);
  wire w_txd = wr_d & hit(wa, `ESP_A_TXD);
  wire w_stat = wr_d & hit(wa, `ESP_A_STAT);
  wire w_dir = wr_d & hit(wa, `ESP_A_DIR);
  wire w_latc = wr_d & hit(wa, `ESP_A_LATC);
  wire w_pgl = wr_d & hit(wa, `ESP_A_PGL);
  wire rd_rxd = rd & hit(ra, `ESP_A_RXD);

  // Control fields
  wire en = ctrl_ff[`ESP_C_EN];
  wire sync_m = ctrl_ff[`ESP_C_SYNC];
  wire mst = ctrl_ff[`ESP_C_MST];
  wire pol = ctrl_ff[`ESP_C_POL];
  wire txe = ctrl_ff[`ESP_C_TXE];
  wire rxe = ctrl_ff[`ESP_C_RXE];
  wire wke = ctrl_ff[`ESP_C_WAKE];
  wire abe = ctrl_ff[`ESP_C_ABD];
  wire sbk = ctrl_ff[`ESP_C_BRK];

  // Sequencer state decode
  wire tx_idle = (tx_st_ff == esp_pkg::ESP_TX_IDLE);
  wire rx_idle = (rx_st_ff == esp_pkg::ESP_RX_IDLE);
  wire busy = ~tx_idle;
  wire [5:0] stat = {abd_run_ff, wkf_ff, fer_ff, ovr_ff, rxv_ff, busy};

  // Transfer launch; only one direction at a time in sync mode
  wire tx_go = w_txd & en & txe & tx_idle;
  wire srx_go = en & sync_m & rxe & tx_idle & ~tx_go;

  // Sync clock in idle-low terms; polarity folded in here
  wire kcur = mst ? k_ff : (s6 ^ pol);
  wire trail = ~kcur & kprev_ff;
  wire sdata = sync_m & (tx_st_ff == esp_pkg::ESP_TX_DATA);
  wire s_step = sdata & trail;
  wire s_last = s_step & (tcnt_ff == `ESP_LAST_BIT);
  wire s_rdone = s_last & ~sdir_ff;
  wire brk_done = (tx_st_ff == esp_pkg::ESP_TX_BRK) & ttick & (tcnt_ff == `ESP_LAST_BRK);

  // Async receive runs beside the transmitter; blocked while hunting
  wire arx_ok = en & ~sync_m & rxe & ~wke & ~abe;
  wire rx_fall = rx_prev_ff & ~s7;
  wire rx_rise = ~rx_prev_ff & s7;
  wire r_go = arx_ok & rx_idle & rx_fall;
  wire a_done = (rx_st_ff == esp_pkg::ESP_RX_STOP) & rtick;
  wire a_fer = a_done & ~s7;
  wire rx_done = a_done | s_rdone;
  wire [7:0] rx_byte = s_rdone ? {s7, tsh_ff[7:1]} : rsh_ff;

  // Break end on the line raises the wake flag
  wire wake_hit = wke & en & ~sync_m & rx_rise;

  // Auto-baud: first to fifth falling edge of the sync byte is 8 bits
  wire abd_start = en & ~sync_m & abe & ~abd_run_ff & rx_fall;
  wire abd_done = abd_run_ff & rx_fall & (abd_edges_ff == `ESP_ABD_LAST);
  wire [15:0] abd_val = abd_cnt_ff[18:`ESP_ABD_SHIFT];

  // Pin requests
  wire six_out = sync_m ? (k_ff ^ pol) : tline_ff;
  wire six_oe = sync_m ? mst : txe;
  assign d6 = {six_out, six_oe};
  assign d7 = {tsh_ff[0], sdata & sdir_ff};

  // Read data prepared in the address phase
  wire [31:0] rmux =
    hit(ra, `ESP_A_CTRL) ? {23'h000000, ctrl_ff} :
    hit(ra, `ESP_A_BAUD) ? {16'h0000, baud_ff} :
    hit(ra, `ESP_A_RXD) ? {24'h000000, rxbuf_ff} :
    hit(ra, `ESP_A_STAT) ? {26'h0000000, stat} :
    hit(ra, `ESP_A_DIR) ? {24'h000000, dir_ff} :
    hit(ra, `ESP_A_LATC) ? {24'h000000, latc_ff} :
    hit(ra, `ESP_A_PGL) ? {24'h000000, pgl_ff} : 32'h00000000;

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign wake_o = wkf_ff;

  esp_brg u_tx_brg (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(~tx_idle),
    .load(tx_go | srx_go),
    .load_val(baud_ff),
    .period(baud_ff),
    .tick(ttick)
  );

  // Receiver samples mid-bit: first reload is half a bit
  esp_brg u_rx_brg (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(~rx_idle),
    .load(r_go),
    .load_val({1'b0, baud_ff[15:1]}),
    .period(baud_ff),
    .tick(rtick)
  );

  esp_pins u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(en),
    .od(pgl_ff[`ESP_P_SIX]),
    .dir({dir_ff[`ESP_P_SEVEN], dir_ff[`ESP_P_SIX]}),
    .lat({latc_ff[`ESP_P_SEVEN], latc_ff[`ESP_P_SIX]}),
    .drv6(d6),
    .drv7(d7),
    .pin6_i(port_c_line_six_i),
    .pin7_i(port_c_line_seven_i),
    .pin6_o(port_c_line_six_o),
    .pin6_oe(port_c_line_six_oe),
    .pin7_o(port_c_line_seven_o),
    .pin7_oe(port_c_line_seven_oe),
    .s6(s6),
    .s7(s7)
  );

  // Bus slave: always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= '0;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      aph_ff <= {acc, hwrite, ra};
      if (rd) hrdata_ff <= rmux;
    end
  end

  // Control and port registers; software write wins over hardware clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `ESP_CTRL_RST;
      dir_ff <= `ESP_DIR_RST;
      latc_ff <= `ESP_LAT_RST;
      pgl_ff <= `ESP_LAT_RST;
    end else begin
      if (w_ctrl) begin
        ctrl_ff <= hwdata[`ESP_C_W-1:0];
      end else begin
        if (brk_done) ctrl_ff[`ESP_C_BRK] <= 1'b0;
        if (wake_hit) ctrl_ff[`ESP_C_WAKE] <= 1'b0;
        if (abd_done) ctrl_ff[`ESP_C_ABD] <= 1'b0;
      end
      if (w_dir) dir_ff <= hwdata[7:0];
      if (w_latc) latc_ff <= hwdata[7:0];
      if (w_pgl) pgl_ff <= hwdata[7:0];
    end
  end

  // Baud divisor; a finished measurement overrides a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_ff <= `ESP_BAUD_RST;
    end else if (abd_done) begin
      baud_ff <= abd_val;
    end else if (w_baud) begin
      baud_ff <= hwdata[15:0];
    end
  end

  // Status flags: hardware set beats software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxbuf_ff <= 8'h00;
      rxv_ff <= 1'b0;
      ovr_ff <= 1'b0;
      fer_ff <= 1'b0;
      wkf_ff <= 1'b0;
    end else begin
      if (rx_done) rxbuf_ff <= rx_byte;
      if (rx_done) rxv_ff <= 1'b1;
      else if (rd_rxd) rxv_ff <= 1'b0;
      if (rx_done & rxv_ff & ~rd_rxd) ovr_ff <= 1'b1;
      else if (w_stat & hwdata[`ESP_S_OVR]) ovr_ff <= 1'b0;
      if (a_fer) fer_ff <= 1'b1;
      else if (w_stat & hwdata[`ESP_S_FER]) fer_ff <= 1'b0;
      if (wake_hit) wkf_ff <= 1'b1;
      else if (w_stat & hwdata[`ESP_S_WAKE]) wkf_ff <= 1'b0;
    end
  end

  // Edge history; safe to read, these follow the second sync stage, or k_ff for a sync master
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_prev_ff <= `ESP_LINE_IDLE;
      kprev_ff <= 1'b0;
    end else begin
      rx_prev_ff <= s7;
      kprev_ff <= kcur;
    end
  end

  // Transmit, break and synchronous transfer sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_ff <= esp_pkg::ESP_TX_IDLE;
      tsh_ff <= 8'h00;
      tcnt_ff <= 4'h0;
      tline_ff <= `ESP_LINE_IDLE;
      sdir_ff <= 1'b0;
      k_ff <= 1'b0;
    end else if (!en) begin
      tx_st_ff <= esp_pkg::ESP_TX_IDLE;
      tline_ff <= `ESP_LINE_IDLE;
      k_ff <= 1'b0;
    end else begin
      unique case (tx_st_ff)
        esp_pkg::ESP_TX_IDLE: begin
          if (tx_go | srx_go) begin
            tsh_ff <= tx_go ? hwdata[7:0] : 8'h00;
            tcnt_ff <= 4'h0;
            sdir_ff <= tx_go;
            if (sync_m) begin
              tx_st_ff <= esp_pkg::ESP_TX_DATA;
            end else begin
              tline_ff <= 1'b0;
              tx_st_ff <= sbk ? esp_pkg::ESP_TX_BRK : esp_pkg::ESP_TX_START;
            end
          end
        end
        esp_pkg::ESP_TX_START: begin
          if (ttick) begin
            tline_ff <= tsh_ff[0];
            tx_st_ff <= esp_pkg::ESP_TX_DATA;
          end
        end
        esp_pkg::ESP_TX_DATA: begin
          if (sync_m) begin
            if (mst & ttick) k_ff <= ~k_ff;
            if (s_step) begin
              tsh_ff <= {s7, tsh_ff[7:1]};
              tcnt_ff <= tcnt_ff + 4'h1;
              if (s_last) tx_st_ff <= esp_pkg::ESP_TX_IDLE;
            end
          end else if (ttick) begin
            if (tcnt_ff == `ESP_LAST_BIT) begin
              tline_ff <= `ESP_LINE_IDLE;
              tx_st_ff <= esp_pkg::ESP_TX_STOP;
            end else begin
              tsh_ff <= {1'b0, tsh_ff[7:1]};
              tline_ff <= tsh_ff[1];
              tcnt_ff <= tcnt_ff + 4'h1;
            end
          end
        end
        esp_pkg::ESP_TX_STOP: begin
          if (ttick) tx_st_ff <= esp_pkg::ESP_TX_IDLE;
        end
        esp_pkg::ESP_TX_BRK: begin
          if (ttick) begin
            tcnt_ff <= tcnt_ff + 4'h1;
            if (brk_done) begin
              tline_ff <= `ESP_LINE_IDLE;
              tx_st_ff <= esp_pkg::ESP_TX_STOP;
            end
          end
        end
      endcase
    end
  end

  // Asynchronous receiver
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_ff <= esp_pkg::ESP_RX_IDLE;
      rsh_ff <= 8'h00;
      rcnt_ff <= 4'h0;
    end else if (!arx_ok) begin
      rx_st_ff <= esp_pkg::ESP_RX_IDLE;
    end else begin
      unique case (rx_st_ff)
        esp_pkg::ESP_RX_IDLE: begin
          if (rx_fall) rx_st_ff <= esp_pkg::ESP_RX_START;
        end
        esp_pkg::ESP_RX_START: begin
          if (rtick) begin
            rcnt_ff <= 4'h0;
            rx_st_ff <= s7 ? esp_pkg::ESP_RX_IDLE : esp_pkg::ESP_RX_DATA;
          end
        end
        esp_pkg::ESP_RX_DATA: begin
          if (rtick) begin
            rsh_ff <= {s7, rsh_ff[7:1]};
            rcnt_ff <= rcnt_ff + 4'h1;
            if (rcnt_ff == `ESP_LAST_BIT) rx_st_ff <= esp_pkg::ESP_RX_STOP;
          end
        end
        esp_pkg::ESP_RX_STOP: begin
          if (rtick) rx_st_ff <= esp_pkg::ESP_RX_IDLE;
        end
      endcase
    end
  end

  // Auto-baud timer; a long idle can wrap the counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abd_run_ff <= 1'b0;
      abd_edges_ff <= 3'h0;
      abd_cnt_ff <= 19'h00000;
    end else if (abd_start) begin
      abd_run_ff <= 1'b1;
      abd_edges_ff <= 3'h0;
      abd_cnt_ff <= 19'h00000;
    end else if (abd_run_ff) begin
      if (abd_done | ~en | ~abe) abd_run_ff <= 1'b0;
      abd_cnt_ff <= abd_cnt_ff + 19'h00001;
      if (rx_fall) abd_edges_ff <= abd_edges_ff + 3'h1;
    end
  end
endmodule

// ---- sim/esp_monitor.sv ----
`timescale 1ns/10ps
`include "esp_map.svh"
module esp_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic port_c_line_six_o,
  input wire logic port_c_line_six_oe,
  input wire logic port_c_line_seven_oe,
  input wire logic wake_o
);
  logic aph_ff, wr_ff, od_ff;
  logic [7:0] adr_ff;
  logic [5:0] cfg_ff;
  logic [1:0] age_ff;
  // Data-phase decode of a shadow of the bus
  wire take = hsel & htrans[1] & hready;
  wire wr_dp = aph_ff & wr_ff;
  wire rd_dp = aph_ff & ~wr_ff;
  wire ctl_wr = wr_dp & (adr_ff == `ESP_A_CTRL);
  wire od_wr = wr_dp & (adr_ff == `ESP_A_PGL);
  wire wake_clr = wr_dp & (adr_ff == `ESP_A_STAT) & hwdata[`ESP_S_WAKE];
  wire en = cfg_ff[`ESP_C_EN];
  wire syn = cfg_ff[`ESP_C_SYNC];
  wire mst = cfg_ff[`ESP_C_MST];
  wire txe = cfg_ff[`ESP_C_TXE];
  // Only mode bits that hardware never clears; pins lag a write, so age counts settling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= 1'b0;
      wr_ff <= 1'b0;
      adr_ff <= 8'h00;
      cfg_ff <= 6'h00;
      od_ff <= 1'b0;
      age_ff <= 2'h0;
    end else begin
      aph_ff <= take;
      wr_ff <= hwrite;
      adr_ff <= haddr[7:0];
      cfg_ff <= ctl_wr ? hwdata[5:0] : cfg_ff;
      od_ff <= od_wr ? hwdata[`ESP_P_SIX] : od_ff;
      age_ff <= (ctl_wr | od_wr) ? 2'h0 : ((age_ff == 2'h3) ? age_ff : age_ff + 2'h1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_settled;
    en && (age_ff == 2'h3);
  endsequence
  sequence s_dead_read;
    take && !hwrite && ((haddr[7:0] > 8'h1c) || (haddr[7:0] == `ESP_A_TXD));
  endsequence
  a_rx_pin_input: assert property (s_settled ##0 !syn |-> !port_c_line_seven_oe)
    else $error("receive line driven in async mode");
  a_tx_pin_driven: assert property (s_settled ##0 (!syn && txe && !od_ff) |-> port_c_line_six_oe)
    else $error("transmit line not driven in async mode");
  a_slave_clk_in: assert property (s_settled ##0 (syn && !mst && !txe) |->
    !port_c_line_six_oe && !port_c_line_seven_oe)
    else $error("slave drives clock or data while receiving");
  a_master_clk_out: assert property (s_settled ##0 (syn && mst && !od_ff) |-> port_c_line_six_oe)
    else $error("master not driving clock line");
  a_od_never_high: assert property ((od_ff && age_ff == 2'h3) |-> !(port_c_line_six_oe && port_c_line_six_o))
    else $error("open drain line driven high");
  a_wake_flag_held: assert property ((wake_o && !wake_clr && !$past(wake_clr)) |=> wake_o)
    else $error("wake output dropped without clear");
  a_rdata_held: assert property (!rd_dp |-> $stable(hrdata))
    else $error("read data changed without a read");
  a_dead_read_zero: assert property (s_dead_read |=> hrdata == 32'h0)
    else $error("unmapped or write-only read not zero");
endmodule
bind esp_top esp_monitor i_esp_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .port_c_line_six_o(port_c_line_six_o), .port_c_line_six_oe(port_c_line_six_oe),
  .port_c_line_seven_oe(port_c_line_seven_oe), .wake_o(wake_o));

// ---- sim/esp_peer.sv ----
`timescale 1ns/10ps
module esp_peer (
  input wire logic hclk,
  input wire logic line_six,
  input wire logic line_seven,
  output logic drv_six,
  output logic six_en,
  output logic drv_seven,
  output logic seven_en
);
  // Lines start released; the bench pull-ups give the idle high
  initial begin
    drv_six = 1'b1;
    six_en = 1'b0;
    drv_seven = 1'b1;
    seven_en = 1'b0;
  end
  // Async frame on line seven, LSB first, then release
  task automatic send(input int t, input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      drv_seven <= f[i];
      seven_en <= 1'b1;
      repeat (t - 1) @(posedge hclk);
    end
    @(posedge hclk);
    seven_en <= 1'b0;
  endtask
  // Async frame from line six, sampled mid-bit
  task automatic take(input int t, output logic [7:0] d);
    while (line_six !== 1'b0) @(posedge hclk);
    repeat (t / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (t) @(posedge hclk);
      d[i] = line_six;
    end
  endtask
  // Length of one low stretch on line six
  task automatic low_len(output int n);
    n = 0;
    while (line_six !== 1'b0) @(posedge hclk);
    while (line_six === 1'b0) begin
      @(posedge hclk);
      n++;
    end
  endtask
  // Sync data taken at each leading clock edge; idle level equals pol
  task automatic clk_in(input logic pol, output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      while (line_six !== ~pol) @(posedge hclk);
      d[i] = line_seven;
      while (line_six !== pol) @(posedge hclk);
    end
  endtask
  // Clock for an inverted-polarity slave; idle high matches the pull-up, so release adds no edge
  task automatic clk_out(input int h, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      drv_six <= 1'b1;
      six_en <= 1'b1;
      drv_seven <= d[i];
      seven_en <= 1'b1;
      repeat (h) @(posedge hclk);
      drv_six <= 1'b0;
      repeat (h) @(posedge hclk);
      drv_six <= 1'b1;
      repeat (h - 1) @(posedge hclk);
    end
    @(posedge hclk);
    six_en <= 1'b0;
    seven_en <= 1'b0;
  endtask
endmodule

// ---- sim/esp_top_tb.sv ----
`timescale 1ns/10ps
`include "esp_map.svh"
module esp_top_tb;
  localparam logic [31:0] C_EN = 32'h1 << `ESP_C_EN;
  localparam logic [31:0] C_SYNC = 32'h1 << `ESP_C_SYNC;
  localparam logic [31:0] C_MST = 32'h1 << `ESP_C_MST;
  localparam logic [31:0] C_POL = 32'h1 << `ESP_C_POL;
  localparam logic [31:0] C_TXE = 32'h1 << `ESP_C_TXE;
  localparam logic [31:0] C_RXE = 32'h1 << `ESP_C_RXE;
  localparam logic [31:0] C_WAKE = 32'h1 << `ESP_C_WAKE;
  localparam logic [31:0] C_ABD = 32'h1 << `ESP_C_ABD;
  localparam logic [31:0] C_BRK = 32'h1 << `ESP_C_BRK;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, o6, e6, o7, e7, wake_o, p6, q6, p7, q7;
  logic [31:0] hrdata;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Pull-ups hold both lines high when nobody drives
  wire line6 = e6 ? o6 : (q6 ? p6 : 1'b1);
  wire line7 = e7 ? o7 : (q7 ? p7 : 1'b1);
  always #2.5 hclk = ~hclk;
  esp_top i_esp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .port_c_line_six_i(line6), .port_c_line_six_o(o6),
    .port_c_line_six_oe(e6), .port_c_line_seven_i(line7), .port_c_line_seven_o(o7),
    .port_c_line_seven_oe(e7), .wake_o(wake_o));
  esp_peer i_esp_peer (.hclk(hclk), .line_six(line6), .line_seven(line7), .drv_six(p6), .six_en(q6),
    .drv_seven(p7), .seven_en(q7));
  task automatic conclude;
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A hung handshake or frame ends the run here
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask
  // One single AHB transfer; the master waits for hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(n, e, q & m);
  endtask
  task automatic wait_tx;
    logic [31:0] q;
    do ahb(1'b0, `ESP_A_STAT, 32'h0, q); while (q[0] !== 1'b0);
  endtask
  function automatic logic [31:0] brk_len(input int baud);
    return 32'(12 * (baud + 1));
  endfunction
  function automatic logic abd_fit(input logic [31:0] q, input int t);
    return (q === 32'(t)) || (q === 32'(t - 1));
  endfunction
  initial begin
    logic [31:0] q;
    logic [7:0] a, b, r;
    int n;
    void'($urandom(32'h618625f7));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, then a hole in the map
    rd("ctrl", `ESP_A_CTRL, 32'hffffffff, 32'h0);
    rd("baud", `ESP_A_BAUD, 32'hffffffff, 32'hff);
    rd("dir", `ESP_A_DIR, 32'hffffffff, 32'hff);
    rd("pgl", `ESP_A_PGL, 32'hffffffff, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd("hole", 8'h40, 32'hffffffff, 32'h0);
    // Disabled pins follow direction and latch; enabling hands them to the serial logic
    wr(`ESP_A_DIR, 32'h3f);
    wr(`ESP_A_LATC, 32'h40);
    repeat (3) @(posedge hclk);
    chk("pins_off", 32'he, {28'h0, e6, o6, e7, o7});
    wr(`ESP_A_BAUD, 32'h3);
    wr(`ESP_A_CTRL, C_EN | C_TXE | C_RXE);
    repeat (3) @(posedge hclk);
    chk("pins_on", 32'h6, {29'h0, e6, o6, e7});
    wr(`ESP_A_DIR, 32'hff);
    // Both directions at once, with a refused second write while busy
    for (int k = 0; k < 3; k++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      fork
        begin
          wr(`ESP_A_TXD, {24'h0, a});
          wr(`ESP_A_TXD, {24'h0, ~a});
        end
        i_esp_peer.send(4, b);
        i_esp_peer.take(4, r);
      join
      chk("tx_byte", {24'h0, a}, {24'h0, r});
      wait_tx();
      rd("rx_byte", `ESP_A_RXD, 32'hff, {24'h0, b});
    end
    // Break holds the line low for twelve bit times, then high again
    wr(`ESP_A_CTRL, C_EN | C_TXE | C_BRK);
    fork
      wr(`ESP_A_TXD, $urandom);
      i_esp_peer.low_len(n);
    join
    chk("brk_len", brk_len(3), 32'(n));
    wait_tx();
    rd("brk_clr", `ESP_A_CTRL, 32'hffffffff, C_EN | C_TXE);
    // Open drain: the pull-up has to restore every one bit
    wr(`ESP_A_PGL, 32'h40);
    a = 8'($urandom);
    fork
      wr(`ESP_A_TXD, {24'h0, a});
      i_esp_peer.take(4, r);
    join
    chk("od_byte", {24'h0, a}, {24'h0, r});
    wait_tx();
    wr(`ESP_A_PGL, 32'h0);
    // Wake on the rising edge that ends a received break
    wr(`ESP_A_CTRL, C_EN | C_WAKE);
    i_esp_peer.send(4, 8'h00);
    repeat (6) @(posedge hclk);
    chk("wake", 32'h1, {31'h0, wake_o});
    rd("wake_flag", `ESP_A_STAT, 32'h10, 32'h10);
    rd("wake_en", `ESP_A_CTRL, 32'hffffffff, C_EN);
    wr(`ESP_A_STAT, 32'h10);
    repeat (3) @(posedge hclk);
    chk("wake_off", 32'h0, {31'h0, wake_o});
    // Auto-baud on a sync character at sixteen cycles a bit
    wr(`ESP_A_CTRL, C_EN | C_ABD);
    i_esp_peer.send(16, 8'h55);
    ahb(1'b0, `ESP_A_BAUD, 32'h0, q);
    chk("abd", 32'h1, {31'h0, abd_fit(q, 16)});
    rd("abd_clr", `ESP_A_CTRL, C_ABD, 32'h0);
    // Sync master in both clock polarities, data line released after
    wr(`ESP_A_BAUD, 32'h3);
    for (int p = 0; p < 2; p++) begin
      wr(`ESP_A_CTRL, C_EN | C_SYNC | C_MST | C_TXE | (32'(p) << `ESP_C_POL));
      repeat (4) @(posedge hclk);
      chk("clk_idle", 32'(p), {31'h0, o6});
      a = 8'($urandom);
      fork
        wr(`ESP_A_TXD, {24'h0, a});
        i_esp_peer.clk_in(p[0], r);
      join
      chk("sync_tx", {24'h0, a}, {24'h0, r});
      wait_tx();
      chk("data_free", 32'h0, {31'h0, e7});
    end
    // Sync slave with inverted clock, taken from the peer
    wr(`ESP_A_CTRL, C_EN | C_SYNC | C_POL | C_RXE);
    b = 8'($urandom);
    i_esp_peer.clk_out(4, b);
    repeat (8) @(posedge hclk);
    rd("slave_rx", `ESP_A_RXD, 32'hff, {24'h0, b});
    conclude();
  end
endmodule
